// File: hdl/fcp_pkg.sv
package fcp_pkg;
  // media clock periods, in ns
  localparam int MCY_FAST_NS = 250;
  localparam int MCY_SLOW_NS = 500;
  localparam int CLK_NS = 10;
  localparam int MCY_FAST_CYC = MCY_FAST_NS / CLK_NS;
  localparam int MCY_SLOW_CYC = MCY_SLOW_NS / CLK_NS;
  // drive timing in media-clock periods
  localparam int STEP_LOW_MCY = 24;
  localparam int STEP_CYCLE_MCY = 132;
  localparam int DIR_SETUP_MCY = 4;
  localparam int DIR_HOLD_MCY = 96;
  localparam int SEL_HOLD_MCY = 20;
  localparam int INDEX_MIN_MCY = 2;
  localparam int SOFT_RESET_REQUEST_MIN_MCY = 5;
  localparam int IRQ_CLEAR_EXTRA_NS = 100;
  localparam int OP_COUNT = 15;
  localparam int MAX_CMD_BYTES = 9;
  localparam int MAX_RES_BYTES = 7;
  // opcode low five bits
  localparam logic [4:0] OP_READ_DATA = 5'h06;
  localparam logic [4:0] OP_READ_DELETED = 5'h0c;
  localparam logic [4:0] OP_WRITE_DATA = 5'h05;
  localparam logic [4:0] OP_WRITE_DELETED = 5'h09;
  localparam logic [4:0] OP_READ_TRACK = 5'h02;
  localparam logic [4:0] OP_READ_ID = 5'h0a;
  localparam logic [4:0] OP_FORMAT = 5'h0d;
  localparam logic [4:0] OP_SCAN_EQ = 5'h11;
  localparam logic [4:0] OP_SCAN_LE = 5'h19;
  localparam logic [4:0] OP_SCAN_HE = 5'h1d;
  localparam logic [4:0] OP_RECAL = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SENSE_DRIVE = 5'h04;
  localparam logic [4:0] OP_SEEK = 5'h0f;
  localparam int FLAG_MT_BIT = 7;
  localparam int FLAG_MF_BIT = 6;
  localparam int FLAG_SK_BIT = 5;
  localparam int HEAD_BIT = 2;
  // status byte codes, zero to three
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_ABNORMAL = 8'h40;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic [7:0] ST0_NORMAL = 8'h00;
  localparam logic [7:0] ST1_END_CYL = 8'h80;
  localparam logic [7:0] ST1_NO_DATA = 8'h04;
  localparam logic [7:0] ST2_DELETED = 8'h40;
  localparam logic [7:0] ST3_TRACK0 = 8'h10;
  localparam logic [3:0] CMD_LEN_9 = 4'h9;
  localparam logic [3:0] RES_LEN_7 = 4'h7;
  localparam logic [3:0] RES_LEN_1 = 4'h1;
  localparam logic [3:0] RES_LEN_2 = 4'h2;
  localparam logic [3:0] RES_LEN_0 = 4'h0;
  localparam logic [7:0] POS_RESET = 8'h00;
endpackage : fcp_pkg

// File: hdl/fcp_step_if.sv
`timescale 1ns/1ns
interface fcp_step_if;
  logic req;
  logic dir_in;
  logic [1:0] unit;
  logic busy;
  logic done;
  logic step_b;
  logic dir;
  logic [1:0] sel;
  modport core (output req, output dir_in, output unit, input busy, input done,
    input step_b, input dir, input sel);
  modport pacer (input req, input dir_in, input unit, output busy, output done,
    output step_b, output dir, output sel);
endinterface : fcp_step_if

// File: hdl/fcp_mclk.sv
`timescale 1ns/1ns
module fcp_mclk (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_slow_rate,
  output logic o_tick
);
  logic [7:0] count;
  wire logic [7:0] limit;
  // media clock period tracks the rate select
  assign limit = i_slow_rate ? 8'(fcp_pkg::MCY_SLOW_CYC - 1) : 8'(fcp_pkg::MCY_FAST_CYC - 1);
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      count <= 8'h00;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= (count >= limit);
      count <= (count >= limit) ? 8'h00 : count + 8'h01;
    end
  end
endmodule : fcp_mclk

// File: hdl/fcp_stepper.sv
`timescale 1ns/1ns
module fcp_stepper (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_tick,
  fcp_step_if.pacer s
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_GAP} fcp_step_e;
  fcp_step_e state;
  logic [7:0] count;
  wire logic count_end;
  wire logic [7:0] setup_len;
  wire logic [7:0] low_len;
  wire logic [7:0] gap_len;
  // one spare tick: the request may land just before a tick
  assign setup_len = 8'(fcp_pkg::DIR_SETUP_MCY + 1);
  assign low_len = 8'(fcp_pkg::STEP_LOW_MCY);
  // rest of cycle; covers direction and select hold too
  assign gap_len = 8'(fcp_pkg::STEP_CYCLE_MCY - fcp_pkg::STEP_LOW_MCY);
  assign count_end = i_tick && (count == 8'h01);
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= ST_IDLE;
      count <= 8'h00;
      s.step_b <= 1'b1;
      s.dir <= 1'b0;
      s.sel <= 2'h0;
      s.done <= 1'b0;
    end
    else
    begin
      s.done <= 1'b0;
      if (i_tick && count != 8'h00)
      begin
        count <= count - 8'h01;
      end
      case (state)
        ST_IDLE:
        begin
          if (s.req)
          begin
            s.dir <= s.dir_in;
            s.sel <= s.unit;
            count <= setup_len;
            state <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          if (count_end)
          begin
            s.step_b <= 1'b0;
            count <= low_len;
            state <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          if (count_end)
          begin
            s.step_b <= 1'b1;
            count <= gap_len;
            state <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          // dir and sel frozen until here
          if (count_end)
          begin
            s.done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  assign s.busy = (state != ST_IDLE);
endmodule : fcp_stepper

// File: hdl/fcp_core.sv
// Design decisions made here: the strobed register port, which has no register addresses.
`timescale 1ns/1ns
// Operation
// - fifteen opcodes decoded and executed
// - multibyte command in, multibyte result out
// - command, execution, result phases in order
// - execute only after all parameter bytes
// - status bytes readable after execution
// - nine command bytes, seven result bytes
// - four id bytes, then eot gap length
// - three status bytes then id bytes
// - step low 24, cycle 132 periods
// - direction setup 4, hold 96 periods
// - drive select held 20 after step
// - interrupt dropped within one period plus
// - media period follows data rate
module fcp_core (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_slow_rate,
  input wire logic i_soft_reset_request,
  input wire logic i_transfer_end_strobe,
  input wire logic i_software_transfer_end,
  input wire logic i_index_pulse,
  input wire logic i_track0,
  input wire logic i_transfer_acknowledge,
  output logic o_dma_request,
  output logic o_irq,
  output logic o_cmd_ready,
  output logic o_res_ready,
  output logic o_busy,
  output logic o_step_b,
  output logic o_head_move_direction,
  output logic [1:0] o_drive_select_line
);
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_EXEC, PH_STEP, PH_RES} fcp_phase_e;
  fcp_phase_e phase;
  logic [7:0] cmd [fcp_pkg::MAX_CMD_BYTES];
  logic [7:0] res [fcp_pkg::MAX_RES_BYTES];
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [3:0] cmd_len;
  logic [3:0] res_len;
  logic [7:0] cyl;
  logic [7:0] target;
  logic [7:0] soft_reset_request_cnt;
  logic soft_rst;
  logic pending_int;
  logic tc_seen;
  logic idx_q;
  logic [7:0] idx_cnt;
  logic index_seen;
  logic tick;
  fcp_step_if step ();

  fcp_mclk u_mclk (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_slow_rate(i_slow_rate),
    .o_tick(tick)
  );

  fcp_stepper u_stepper (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_tick(tick),
    .s(step.pacer)
  );

  function automatic logic [3:0] op_len(input logic [4:0] op);
    case (op)
      fcp_pkg::OP_READ_DATA, fcp_pkg::OP_READ_DELETED, fcp_pkg::OP_WRITE_DATA,
      fcp_pkg::OP_WRITE_DELETED, fcp_pkg::OP_READ_TRACK, fcp_pkg::OP_SCAN_EQ,
      fcp_pkg::OP_SCAN_LE, fcp_pkg::OP_SCAN_HE: op_len = fcp_pkg::CMD_LEN_9;
      fcp_pkg::OP_READ_ID, fcp_pkg::OP_RECAL, fcp_pkg::OP_SENSE_DRIVE: op_len = 4'h2;
      fcp_pkg::OP_FORMAT: op_len = 4'h6;
      fcp_pkg::OP_SPECIFY, fcp_pkg::OP_SEEK: op_len = 4'h3;
      fcp_pkg::OP_SENSE_INT: op_len = 4'h1;
      default: op_len = 4'h0;
    endcase
  endfunction : op_len

  function automatic logic op_data(input logic [4:0] op);
    op_data = (op_len(op) == fcp_pkg::CMD_LEN_9) || (op == fcp_pkg::OP_READ_ID)
      || (op == fcp_pkg::OP_FORMAT);
  endfunction : op_data

  wire logic [4:0] opcode;
  wire logic [4:0] new_op;
  wire logic [3:0] new_len;
  wire logic [1:0] unit;
  wire logic head;
  wire logic tc_any;
  wire logic is_seek;
  wire logic is_recal;
  wire logic step_needed;
  wire logic [7:0] st0_unit;
  wire logic cmd_complete;
  wire logic bad_write;
  wire logic bad_read;
  wire logic result_drained;
  wire logic dma_end;

  assign opcode = cmd[0][4:0];
  assign new_op = i_wdata[4:0];
  assign new_len = op_len(new_op);
  assign unit = cmd[1][1:0];
  assign head = cmd[1][fcp_pkg::HEAD_BIT];
  assign tc_any = i_transfer_end_strobe || i_software_transfer_end;
  assign is_seek = (opcode == fcp_pkg::OP_SEEK);
  assign is_recal = (opcode == fcp_pkg::OP_RECAL);
  assign step_needed = (is_recal && !i_track0 && cyl != 8'h00) || (is_seek && cyl != target);
  assign st0_unit = {5'h00, head, unit};
  assign cmd_complete = i_wr && (phase == PH_CMD) && (wr_idx + 4'h1 == cmd_len);
  assign bad_write = i_wr && (phase == PH_EXEC || phase == PH_STEP || phase == PH_RES);
  assign bad_read = i_rd && (phase != PH_RES);
  assign result_drained = i_rd && (phase == PH_RES) && (rd_idx + 4'h1 >= res_len);
  assign dma_end = tc_any || tc_seen || index_seen;

  // index must stay low two periods before it counts
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      idx_q <= 1'b1;
      idx_cnt <= 8'h00;
      index_seen <= 1'b0;
    end
    else
    begin
      idx_q <= i_index_pulse;
      index_seen <= 1'b0;
      if (idx_q)
        idx_cnt <= 8'h00;
      else if (tick && idx_cnt != 8'hff)
        idx_cnt <= idx_cnt + 8'h01;
      if (!idx_q && tick && idx_cnt == 8'(fcp_pkg::INDEX_MIN_MCY - 1))
        index_seen <= 1'b1;
    end
  end

  // soft reset takes effect once held long enough
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      soft_reset_request_cnt <= 8'h00;
      soft_rst <= 1'b0;
    end
    else
    begin
      if (!i_soft_reset_request)
        soft_reset_request_cnt <= 8'h00;
      else if (tick && soft_reset_request_cnt != 8'hff)
        soft_reset_request_cnt <= soft_reset_request_cnt + 8'h01;
      soft_rst <= i_soft_reset_request && (soft_reset_request_cnt >= 8'(fcp_pkg::SOFT_RESET_REQUEST_MIN_MCY));
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      phase <= PH_IDLE;
      wr_idx <= 4'h0;
      rd_idx <= 4'h0;
      cmd_len <= 4'h0;
      res_len <= 4'h0;
      cyl <= fcp_pkg::POS_RESET;
      target <= fcp_pkg::POS_RESET;
      pending_int <= 1'b0;
      tc_seen <= 1'b0;
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
      o_dma_request <= 1'b0;
      for (int i = 0; i < fcp_pkg::MAX_CMD_BYTES; i++)
        cmd[i] <= 8'h00;
      for (int i = 0; i < fcp_pkg::MAX_RES_BYTES; i++)
        res[i] <= 8'h00;
    end
    else if (soft_rst)
    begin
      phase <= PH_IDLE;
      wr_idx <= 4'h0;
      rd_idx <= 4'h0;
      o_irq <= 1'b0;
      o_dma_request <= 1'b0;
      pending_int <= 1'b0;
      tc_seen <= 1'b0;
    end
    else
    begin
      o_rdata <= 8'h00;
      if (i_rd || i_wr)
        o_irq <= 1'b0;
      if (bad_write || bad_read)
      begin
        res[0] <= fcp_pkg::ST0_INVALID;
        res_len <= fcp_pkg::RES_LEN_1;
        rd_idx <= 4'h0;
        phase <= PH_RES;
      end
      case (phase)
        PH_IDLE:
        begin
          if (i_wr)
          begin
            cmd[0] <= i_wdata;
            cmd_len <= new_len;
            wr_idx <= 4'h1;
            if (new_len == 4'h0)
            begin
              res[0] <= fcp_pkg::ST0_INVALID;
              res_len <= fcp_pkg::RES_LEN_1;
              rd_idx <= 4'h0;
              phase <= PH_RES;
            end
            else if (new_len == 4'h1)
              phase <= PH_EXEC;
            else
              phase <= PH_CMD;
          end
        end
        PH_CMD:
        begin
          if (i_wr)
          begin
            cmd[wr_idx] <= i_wdata;
            wr_idx <= wr_idx + 4'h1;
            if (cmd_complete)
              phase <= PH_EXEC;
          end
        end
        PH_EXEC:
        begin
          if (is_seek || is_recal)
          begin
            target <= is_seek ? cmd[2] : 8'h00;
            phase <= PH_STEP;
          end
          else if (op_data(opcode))
          begin
            o_dma_request <= !dma_end && !i_transfer_acknowledge && !bad_write && !bad_read;
            if (tc_any)
              tc_seen <= 1'b1;
            if (dma_end)
            begin
              tc_seen <= 1'b0;
              o_dma_request <= 1'b0;
              res[0] <= (tc_any || tc_seen) ? st0_unit : (fcp_pkg::ST0_ABNORMAL | st0_unit);
              res[1] <= (tc_any || tc_seen) ? 8'h00 : fcp_pkg::ST1_END_CYL;
              res[2] <= (opcode == fcp_pkg::OP_READ_DELETED) ? fcp_pkg::ST2_DELETED : 8'h00;
              res[3] <= cmd[2];
              res[4] <= cmd[3];
              res[5] <= cmd[4];
              res[6] <= cmd[5];
              res_len <= (opcode == fcp_pkg::OP_READ_ID || opcode == fcp_pkg::OP_FORMAT)
                ? fcp_pkg::RES_LEN_7 : fcp_pkg::RES_LEN_7;
              rd_idx <= 4'h0;
              o_irq <= 1'b1;
              phase <= PH_RES;
            end
          end
          else
          begin
            rd_idx <= 4'h0;
            case (opcode)
              fcp_pkg::OP_SENSE_INT:
              begin
                res[0] <= pending_int ? fcp_pkg::ST0_SEEK_END : fcp_pkg::ST0_INVALID;
                res[1] <= cyl;
                res_len <= pending_int ? fcp_pkg::RES_LEN_2 : fcp_pkg::RES_LEN_1;
                pending_int <= 1'b0;
                phase <= PH_RES;
              end
              fcp_pkg::OP_SENSE_DRIVE:
              begin
                res[0] <= (i_track0 ? fcp_pkg::ST3_TRACK0 : 8'h00) | st0_unit;
                res_len <= fcp_pkg::RES_LEN_1;
                phase <= PH_RES;
              end
              default:
              begin
                res_len <= fcp_pkg::RES_LEN_0;
                phase <= PH_IDLE;
              end
            endcase
          end
        end
        PH_STEP:
        begin
          if (!step.busy && !step.req)
          begin
            if (step.done)
              cyl <= (step.dir) ? cyl + 8'h01 : cyl - 8'h01;
            else if (!step_needed)
            begin
              if (is_recal)
                cyl <= 8'h00;
              pending_int <= 1'b1;
              o_irq <= 1'b1;
              phase <= PH_IDLE;
            end
          end
        end
        PH_RES:
        begin
          if (i_rd)
          begin
            o_rdata <= res[rd_idx[2:0]];
            rd_idx <= rd_idx + 4'h1;
            if (result_drained)
              phase <= PH_IDLE;
          end
        end
        default:
        begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  logic step_req;
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      step_req <= 1'b0;
    else
      step_req <= (phase == PH_STEP) && step_needed && !step.busy && !step.done && !step_req;
  end
  assign step.req = step_req;
  assign step.dir_in = is_seek && (target > cyl);
  assign step.unit = unit;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_cmd_ready <= 1'b0;
      o_res_ready <= 1'b0;
      o_busy <= 1'b0;
      o_step_b <= 1'b1;
      o_head_move_direction <= 1'b0;
      o_drive_select_line <= 2'h0;
    end
    else
    begin
      o_cmd_ready <= (phase == PH_IDLE || phase == PH_CMD);
      o_res_ready <= (phase == PH_RES);
      o_busy <= (phase != PH_IDLE);
      o_step_b <= step.step_b;
      o_head_move_direction <= step.dir;
      o_drive_select_line <= step.sel;
    end
  end
endmodule : fcp_core

// File: tb/fcp_core_monitor.sv
`timescale 1ns/1ns
module fcp_core_monitor (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_slow_rate,
  input wire logic i_soft_reset_request,
  input wire logic i_transfer_end_strobe,
  input wire logic i_software_transfer_end,
  input wire logic i_index_pulse,
  input wire logic i_track0,
  input wire logic i_transfer_acknowledge,
  input wire logic o_dma_request,
  input wire logic o_irq,
  input wire logic o_cmd_ready,
  input wire logic o_res_ready,
  input wire logic o_busy,
  input wire logic o_step_b,
  input wire logic o_head_move_direction,
  input wire logic [1:0] o_drive_select_line
);
  int media_clock_period;
  int lo_n;
  int fall_n;
  int rise_n;
  int dir_n;
  logic step_q;
  logic dir_q;
  assign media_clock_period = i_slow_rate ? fcp_pkg::MCY_SLOW_CYC : fcp_pkg::MCY_FAST_CYC;
  // cycles since step edges and since the last direction change
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      step_q <= 1'b1;
      dir_q <= 1'b0;
      lo_n <= 0;
      fall_n <= 99999;
      rise_n <= 99999;
      dir_n <= 99999;
    end
    else
    begin
      step_q <= o_step_b;
      dir_q <= o_head_move_direction;
      lo_n <= o_step_b ? 0 : lo_n + 1;
      fall_n <= (step_q && !o_step_b) ? 0 : fall_n + 1;
      rise_n <= (!step_q && o_step_b) ? 0 : rise_n + 1;
      dir_n <= (dir_q != o_head_move_direction) ? 0 : dir_n + 1;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_step_fall;
    o_step_b ##1 !o_step_b;
  endsequence
  sequence s_host_touch;
    (i_rd || i_wr) && o_irq;
  endsequence
  property p_step_low;
    $rose(o_step_b) |-> lo_n >= fcp_pkg::STEP_LOW_MCY * media_clock_period;
  endproperty
  a_step_low: assert property (p_step_low) else $error("step pulse too short");
  property p_step_cycle;
    s_step_fall |-> fall_n + 1 >= fcp_pkg::STEP_CYCLE_MCY * media_clock_period;
  endproperty
  a_step_cycle: assert property (p_step_cycle) else $error("steps too close");
  property p_dir_setup;
    s_step_fall |-> dir_n + 1 >= fcp_pkg::DIR_SETUP_MCY * media_clock_period;
  endproperty
  a_dir_setup: assert property (p_dir_setup) else $error("direction setup short");
  property p_dir_hold;
    $changed(o_head_move_direction) |-> rise_n + 1 >= fcp_pkg::DIR_HOLD_MCY * media_clock_period;
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction hold short");
  property p_sel_hold;
    $changed(o_drive_select_line) |-> fall_n + 1 >= fcp_pkg::SEL_HOLD_MCY * media_clock_period;
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("drive select hold short");
  property p_irq_drop;
    s_host_touch |-> ##[1:2] !o_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt not withdrawn");
  property p_dma_ack;
    i_transfer_acknowledge && o_dma_request |=> !o_dma_request;
  endproperty
  a_dma_ack: assert property (p_dma_ack) else $error("request kept after ack");
  property p_dma_phase;
    o_dma_request |-> o_busy && !o_cmd_ready && !o_res_ready;
  endproperty
  a_dma_phase: assert property (p_dma_phase) else $error("transfer outside execution");
  property p_res_phase;
    o_res_ready |-> o_busy && !o_cmd_ready;
  endproperty
  a_res_phase: assert property (p_res_phase) else $error("result phase overlap");
endmodule : fcp_core_monitor
bind fcp_core fcp_core_monitor i_mon (.*);

// File: tb/fcp_drive_model.sv
`timescale 1ns/1ns
module fcp_drive_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_step_b,
  input wire logic i_dir,
  input wire logic i_dma_request,
  output logic o_index_b,
  output logic o_track0,
  output logic o_transfer_acknowledge
);
  int cyl;
  int ix_n;
  int wait_n;
  int gap_n;
  logic step_q;
  logic slow;
  logic answer;
  assign o_track0 = (cyl == 0);
  assign o_index_b = (ix_n >= 150);
  // alternate prompt and late answers, spaced for the slow rate
  assign answer = i_dma_request && !o_transfer_acknowledge && wait_n >= (slow ? 500 : 2) && gap_n >= 2600;
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cyl <= 0;
      ix_n <= 0;
      wait_n <= 0;
      gap_n <= 2600;
      step_q <= 1'b1;
      slow <= 1'b0;
      o_transfer_acknowledge <= 1'b0;
    end
    else
    begin
      step_q <= i_step_b;
      if (step_q && !i_step_b)
        cyl <= i_dir ? cyl + 1 : (cyl > 0 ? cyl - 1 : 0);
      ix_n <= (ix_n == 4999) ? 0 : ix_n + 1;
      wait_n <= (i_dma_request && !o_transfer_acknowledge) ? wait_n + 1 : 0;
      gap_n <= o_transfer_acknowledge ? 0 : gap_n + 1;
      slow <= o_transfer_acknowledge ? !slow : slow;
      o_transfer_acknowledge <= answer;
    end
  end
endmodule : fcp_drive_model

// File: tb/test_floppy_command_phase_and_drive_timing.sv
`timescale 1ns/1ns
`define CHK(nm, got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_floppy_command_phase_and_drive_timing;
  logic i_clock = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, i_slow_rate = 0;
  logic i_soft_reset_request = 0, i_transfer_end_strobe = 0, i_software_transfer_end = 0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_dma_request, o_irq, o_cmd_ready, o_res_ready, o_busy, o_step_b;
  logic o_head_move_direction, index_b, track0, transfer_acknowledge, rd_d = 0;
  logic [1:0] o_drive_select_line;
  int bad_count = 0, check_count = 0, cyc = 0, lo_w = 0, last_w = 0, i, j;
  logic [31:0] seed = 32'ha501;
  logic [7:0] eq[$], mq[$], cmd[9], cyl, e, m;
  logic [7:0] ops[15] = '{8'h06, 8'h0c, 8'h05, 8'h09, 8'h02, 8'h0a, 8'h0d, 8'h11,
    8'h19, 8'h1d, 8'h03, 8'h04, 8'h0f, 8'h08, 8'h07};
  int lens[15] = '{9, 9, 9, 9, 9, 2, 6, 9, 9, 9, 3, 2, 3, 1, 2};
  int nres[15] = '{7, 7, 7, 7, 7, 7, 7, 7, 7, 7, 0, 1, 0, 2, 0};
  logic [7:0] bad_ops[4] = '{8'h00, 8'h01, 8'h0e, 8'h1f};
  always #5 i_clock = ~i_clock;
  fcp_core i_dut (.*, .i_index_pulse(index_b), .i_track0(track0),
    .i_transfer_acknowledge(transfer_acknowledge));
  fcp_drive_model i_drive (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_step_b(o_step_b),
    .i_dir(o_head_move_direction), .i_dma_request(o_dma_request), .o_index_b(index_b),
    .o_track0(track0), .o_transfer_acknowledge(transfer_acknowledge));
  function logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge i_clock)
  begin
    rd_d <= i_rd;
    cyc <= cyc + 1;
    lo_w <= o_step_b ? 0 : lo_w + 1;
    if (!o_step_b)
      last_w <= lo_w + 1;
    if (cyc == 95000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  // result byte stands in the cycle after the read strobe
  always @(negedge i_clock)
  begin
    if (rd_d && eq.size() > 0)
    begin
      e = eq.pop_front();
      m = mq.pop_front();
      `CHK("result byte", o_rdata & m, e & m)
    end
  end
  task wr(input logic [7:0] b);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_wdata <= b;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic chk, input logic [7:0] ev, input logic [7:0] mv);
    if (chk)
    begin
      eq.push_back(ev);
      mq.push_back(mv);
    end
    @(posedge i_clock);
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask : rd
  task run(input int n, input int nr, input logic [7:0] e0, input logic [7:0] m0,
    input logic sw);
    int k;
    logic [7:0] ev, mv;
    for (k = 0; k < n; k++)
      wr(cmd[k]);
    repeat (2) @(posedge i_clock);
    for (k = 0; k < 40000 && o_busy === 1'b1 && o_res_ready !== 1'b1; k++)
    begin
      @(posedge i_clock);
      if (transfer_acknowledge && sw)
        i_software_transfer_end <= 1'b1;
      if (transfer_acknowledge && !sw)
        i_transfer_end_strobe <= 1'b1;
    end
    @(posedge i_clock);
    i_transfer_end_strobe <= 1'b0;
    i_software_transfer_end <= 1'b0;
    `CHK("result ready", o_res_ready, nr > 0)
    for (k = 0; k < nr; k++)
    begin
      ev = (k == 0) ? e0 : 8'h00;
      mv = (k == 0) ? m0 : 8'h00;
      if (cmd[0][4:0] == fcp_pkg::OP_READ_DATA && k > 2)
      begin
        ev = cmd[k - 1];
        mv = 8'hff;
      end
      if (cmd[0] == 8'h08 && k == 1)
      begin
        ev = cyl;
        mv = 8'hff;
      end
      rd(1'b1, ev, mv);
    end
    repeat (2) @(posedge i_clock);
  endtask : run
  task fill(input logic [7:0] op);
    for (j = 0; j < 9; j++)
    begin
      seed = nxt(seed);
      cmd[j] = seed[7:0];
    end
    cmd[0] = (op == 8'h06) ? {cmd[0][7:5], op[4:0]} : op;
    cmd[1] = {5'h00, cmd[1][2:0]};
  endtask : fill
  initial
  begin
    cyl = 8'h03;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (32 * fcp_pkg::MCY_FAST_CYC) @(posedge i_clock);
    `CHK("step idle", o_step_b, 1'b1)
    `CHK("idle ready", o_cmd_ready & !o_busy, 1'b1)
    for (i = 0; i < 15; i++)
    begin
      fill(ops[i]);
      if (ops[i] == 8'h0f)
        cmd[2] = cyl;
      if (ops[i] == 8'h08)
        `CHK("seek irq", o_irq, 1'b1)
      if (i == 0)
        run(9, 7, {6'h00, cmd[1][1:0]}, 8'hc3, 1'b0);
      else
        run(lens[i], nres[i], 8'h20, (ops[i] == 8'h08) ? 8'he0 : 8'h00, i[0]);
      if (ops[i] == 8'h0f)
        `CHK("step width", last_w, 24 * fcp_pkg::MCY_FAST_CYC)
      `CHK("result drained", o_res_ready, 1'b0)
    end
    for (i = 0; i < 4; i++)
    begin
      cmd[0] = bad_ops[i];
      run(1, 1, 8'h80, 8'hff, 1'b0);
    end
    rd(1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge i_clock);
    `CHK("idle read refused", o_res_ready, 1'b1)
    rd(1'b1, 8'h80, 8'hff);
    // start just after an index pulse so only the tc can end the transfer
    wait (index_b === 1'b0);
    wait (index_b === 1'b1);
    @(posedge i_clock);
    fill(8'h06);
    run(9, 1, {6'h00, cmd[1][1:0]}, 8'hc3, 1'b1);
    wr(8'h55);
    repeat (2) @(posedge i_clock);
    rd(1'b1, 8'h80, 8'hff);
    fill(8'h06);
    for (i = 0; i < 3; i++)
      wr(cmd[i]);
    i_soft_reset_request <= 1'b1;
    repeat (6 * fcp_pkg::MCY_FAST_CYC) @(posedge i_clock);
    i_soft_reset_request <= 1'b0;
    repeat (40 * fcp_pkg::MCY_FAST_CYC) @(posedge i_clock);
    `CHK("soft reset idle", o_cmd_ready & !o_busy, 1'b1)
    fill(8'h04);
    run(2, 1, 8'h00, 8'h00, 1'b0);
    i_slow_rate <= 1'b1;
    repeat (200) @(posedge i_clock);
    fill(8'h0f);
    cyl = 8'h02;
    cmd[2] = cyl;
    run(3, 0, 8'h00, 8'h00, 1'b0);
    `CHK("slow step width", last_w, 24 * fcp_pkg::MCY_SLOW_CYC)
    `CHK("drive select", o_drive_select_line, cmd[1][1:0])
    `CHK("direction", o_head_move_direction, 1'b1)
    cmd[0] = 8'h08;
    run(1, 2, 8'h20, 8'he0, 1'b0);
    report_and_stop();
  end
endmodule : test_floppy_command_phase_and_drive_timing
